// ### inc/rx_modem_pkg.sv
// Register map, field layout and carrier types of the receive modem configuration bank
package rx_modem_pkg;

  // Register offsets on the serial register port
  localparam logic [6:0] FILTER_BW_ADDR    = 7'h1C;
  localparam logic [6:0] OSR_LOW_ADDR      = 7'h20;
  localparam logic [6:0] OFFS_HIGH_ADDR    = 7'h21;
  localparam logic [6:0] OFFS_MID_ADDR     = 7'h22;
  localparam logic [6:0] OFFS_LOW_ADDR     = 7'h23;
  localparam logic [6:0] GAIN_HIGH_ADDR    = 7'h24;
  localparam logic [6:0] GAIN_LOW_ADDR     = 7'h25;
  localparam logic [6:0] RATE_HIGH_ADDR    = 7'h6E;
  localparam logic [6:0] RATE_LOW_ADDR     = 7'h6F;
  localparam logic [6:0] MOD_CTRL_ONE_ADDR = 7'h70;
  localparam logic [6:0] MOD_CTRL_TWO_ADDR = 7'h71;

  // Storage slot of each register
  localparam int unsigned NUM_REGS      = 11;
  localparam logic [3:0]  IDX_FILTER    = 4'h0;
  localparam logic [3:0]  IDX_OSR_LOW   = 4'h1;
  localparam logic [3:0]  IDX_OFFS_HIGH = 4'h2;
  localparam logic [3:0]  IDX_OFFS_MID  = 4'h3;
  localparam logic [3:0]  IDX_OFFS_LOW  = 4'h4;
  localparam logic [3:0]  IDX_GAIN_HIGH = 4'h5;
  localparam logic [3:0]  IDX_GAIN_LOW  = 4'h6;
  localparam logic [3:0]  IDX_RATE_HIGH = 4'h7;
  localparam logic [3:0]  IDX_RATE_LOW  = 4'h8;
  localparam logic [3:0]  IDX_MOD_ONE   = 4'h9;
  localparam logic [3:0]  IDX_MOD_TWO   = 4'hA;

  // Field positions
  localparam int unsigned SKIP_BIT     = 7;
  localparam int unsigned EXP_MSB      = 6;
  localparam int unsigned EXP_LSB      = 4;
  localparam int unsigned SET_MSB      = 3;
  localparam int unsigned SET_LSB      = 0;
  localparam int unsigned OSR_HI_MSB   = 7;
  localparam int unsigned OSR_HI_LSB   = 5;
  localparam int unsigned NCO_HI_MSB   = 3;
  localparam int unsigned NCO_HI_LSB   = 0;
  localparam int unsigned GAIN_HI_MSB  = 2;
  localparam int unsigned GAIN_HI_LSB  = 0;
  localparam int unsigned SCALE_BIT    = 5;
  localparam int unsigned MANCH_BIT    = 1;
  localparam int unsigned MODTYP_MSB   = 1;
  localparam int unsigned MODTYP_LSB   = 0;
  localparam logic [1:0]  MODTYP_OOK   = 2'h1;

  // Values after reset
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [7:0]  RDATA_RESET  = 8'h00;

  // One decoded access of the serial register port
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } reg_req_t;

  // Settings presented to the demodulator and clock recovery
  typedef struct packed {
    logic        divide_by_three_skip;
    logic [2:0]  decim_exp;
    logic [3:0]  filter_set;
    logic [10:0] osr;
    logic [19:0] nco_offset;
    logic [10:0] loop_gain;
    logic [15:0] rate_word;
    logic        rate_scale;
    logic        manchester;
    logic        ook_mode;
    logic [16:0] eff_rate;
  } modem_cfg_t;

endpackage : rx_modem_pkg

// ### rtl/rx_modem_parameter_config.sv
// Configuration register bank of the receive modem with atomic multi-byte fields
`timescale 1ns/10ps

// How it works
// RQ1 - Filter register: exponent, skip flag, filter set
// RQ2 - Host picks nearest wider filter bandwidth
// RQ3 - FSK demodulation covers index 0.5 to 32
// RQ4 - Manchester bit doubles every rate calculation
// RQ5 - Host estimates modulation bandwidth from index
// RQ6 - With AFC, filter from bandwidth or error
// RQ7 - Without AFC, add twice the frequency error
// RQ8 - Modulation type OOK code selects OOK
// RQ9 - Rate word from 6Eh high, 6Fh low
// RQ10 - Host sets rate scale below 30 kbps
// RQ11 - Register 1Ch sets filter in all modes
// RQ12 - Host picks OOK decimation from effective rate
// RQ13 - Oversampling ratio from 20h and 21h
// RQ14 - Host computes oversampling ratio by formula
// RQ15 - NCO offset spans 21h, 22h, 23h
// RQ16 - Loop gain spans 24h and 25h
// RQ17 - 21h: ratio top bits, offset low nibble
// RQ18 - Field takes effect on its final byte
module rx_modem_parameter_config (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_b_i,
  input  wire rx_modem_pkg::reg_req_t  req_i,
  output logic [7:0]                   rdata_o,
  output rx_modem_pkg::modem_cfg_t     cfg_o,
  output logic                         fsk_mode_o
);
  import rx_modem_pkg::*;

  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] raw;
    modem_cfg_t               cfg;
    logic [7:0]               rdata;
  } state_t;

  state_t st_q;
  state_t st_d;

  // Address decode shared by write and read paths
  function automatic logic [4:0] decode_addr(input logic [6:0] a);
    logic [4:0] r;
    r = 5'h00;
    case (a)
      FILTER_BW_ADDR:    r = {1'b1, IDX_FILTER};
      OSR_LOW_ADDR:      r = {1'b1, IDX_OSR_LOW};
      OFFS_HIGH_ADDR:    r = {1'b1, IDX_OFFS_HIGH};
      OFFS_MID_ADDR:     r = {1'b1, IDX_OFFS_MID};
      OFFS_LOW_ADDR:     r = {1'b1, IDX_OFFS_LOW};
      GAIN_HIGH_ADDR:    r = {1'b1, IDX_GAIN_HIGH};
      GAIN_LOW_ADDR:     r = {1'b1, IDX_GAIN_LOW};
      RATE_HIGH_ADDR:    r = {1'b1, IDX_RATE_HIGH};
      RATE_LOW_ADDR:     r = {1'b1, IDX_RATE_LOW};
      MOD_CTRL_ONE_ADDR: r = {1'b1, IDX_MOD_ONE};
      MOD_CTRL_TWO_ADDR: r = {1'b1, IDX_MOD_TWO};
      default:           r = 5'h00;
    endcase
    return r;
  endfunction : decode_addr

  logic [4:0] dec;
  logic       wr_hit;
  assign dec    = decode_addr(req_i.addr);
  assign wr_hit = req_i.we && dec[4];

  // Next state: byte store, field commit and read return
  always_comb begin
    st_d = st_q;
    if (wr_hit) begin
      st_d.raw[dec[3:0]] = req_i.wdata;
    end
    if (req_i.re) begin
      st_d.rdata = dec[4] ? st_q.raw[dec[3:0]] : 8'h00;
    end
    // Single-byte fields follow their register at once
    st_d.cfg.divide_by_three_skip = st_d.raw[IDX_FILTER][SKIP_BIT];        // RQ1
    st_d.cfg.decim_exp  = st_d.raw[IDX_FILTER][EXP_MSB:EXP_LSB];           // RQ1
    st_d.cfg.filter_set = st_d.raw[IDX_FILTER][SET_MSB:SET_LSB];           // RQ11
    st_d.cfg.rate_scale = st_d.raw[IDX_MOD_ONE][SCALE_BIT];
    st_d.cfg.manchester = st_d.raw[IDX_MOD_ONE][MANCH_BIT];                // RQ4
    st_d.cfg.ook_mode   = (st_d.raw[IDX_MOD_TWO][MODTYP_MSB:MODTYP_LSB]
                          == MODTYP_OOK);                                  // RQ8
    // Multi-byte fields move only on the final byte, so the modem
    // never runs on a half-written value
    if (wr_hit && dec[3:0] == IDX_OFFS_HIGH) begin
      st_d.cfg.osr = {req_i.wdata[OSR_HI_MSB:OSR_HI_LSB],
                      st_q.raw[IDX_OSR_LOW]};                              // RQ13 RQ17 RQ18
    end
    if (wr_hit && dec[3:0] == IDX_OFFS_LOW) begin
      st_d.cfg.nco_offset = {st_q.raw[IDX_OFFS_HIGH][NCO_HI_MSB:NCO_HI_LSB],
                             st_q.raw[IDX_OFFS_MID], req_i.wdata};         // RQ15 RQ17 RQ18
    end
    if (wr_hit && dec[3:0] == IDX_GAIN_LOW) begin
      st_d.cfg.loop_gain = {st_q.raw[IDX_GAIN_HIGH][GAIN_HI_MSB:GAIN_HI_LSB],
                            req_i.wdata};                                  // RQ16 RQ18
    end
    if (wr_hit && dec[3:0] == IDX_RATE_LOW) begin
      st_d.cfg.rate_word = {st_q.raw[IDX_RATE_HIGH], req_i.wdata};         // RQ9 RQ18
    end
    // Effective rate doubles under Manchester coding
    st_d.cfg.eff_rate = st_d.cfg.manchester ? {st_d.cfg.rate_word, 1'b0}
                                            : {1'b0, st_d.cfg.rate_word};  // RQ4
  end

  // State register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o    = st_q.rdata;
  assign cfg_o      = st_q.cfg;
  // FSK path takes any index 0.5 to 32; no limit applied here
  assign fsk_mode_o = !st_q.cfg.ook_mode;                                  // RQ3

  // Checks on the bank
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  a_filter_fields: assert property (                                       // RQ1
    req_i.we && req_i.addr == FILTER_BW_ADDR |=>
      cfg_o.filter_set == $past(req_i.wdata[3:0]) &&
      cfg_o.decim_exp == $past(req_i.wdata[6:4]) &&
      cfg_o.divide_by_three_skip == $past(req_i.wdata[7]))
    else $error("filter fields not taken from register write");

  a_ook_select: assert property (                                          // RQ8
    req_i.we && req_i.addr == MOD_CTRL_TWO_ADDR |=>
      cfg_o.ook_mode == ($past(req_i.wdata[1:0]) == 2'h1) &&
      fsk_mode_o != cfg_o.ook_mode)
    else $error("modulation type not decoded");

  a_rate_commit: assert property (                                         // RQ9
    req_i.we && req_i.addr == RATE_LOW_ADDR |=>
      cfg_o.rate_word == {$past(st_q.raw[IDX_RATE_HIGH]), $past(req_i.wdata)})
    else $error("rate word not assembled");

  a_rate_hold: assert property (                                           // RQ18
    req_i.we && req_i.addr == RATE_HIGH_ADDR |=> $stable(cfg_o.rate_word))
    else $error("rate word moved before final byte");

  a_eff_rate: assert property (                                            // RQ4
    req_i.we && req_i.addr == MOD_CTRL_ONE_ADDR |=>
      cfg_o.eff_rate == 17'(cfg_o.rate_word) *
                        ($past(req_i.wdata[MANCH_BIT]) ? 17'h00002 : 17'h00001))
    else $error("effective rate not doubled correctly");

  a_eff_commit: assert property (                                          // RQ4
    req_i.we && req_i.addr == RATE_LOW_ADDR |=>
      cfg_o.eff_rate == 17'({$past(st_q.raw[IDX_RATE_HIGH]), $past(req_i.wdata)}) *
                        (cfg_o.manchester ? 17'h00002 : 17'h00001))
    else $error("effective rate not refreshed with rate word");

  // Flag bits of 70h take effect on the write itself
  a_manch_bit: assert property (                                           // RQ4
    req_i.we && req_i.addr == MOD_CTRL_ONE_ADDR |=>
      cfg_o.manchester == $past(req_i.wdata[MANCH_BIT]))
    else $error("manchester flag not taken from register write");

  a_scale_flag: assert property (                                          // RQ10
    req_i.we && req_i.addr == MOD_CTRL_ONE_ADDR |=>
      cfg_o.rate_scale == $past(req_i.wdata[SCALE_BIT]))
    else $error("rate scale flag not taken from register write");

  a_osr_commit: assert property (                                          // RQ13
    req_i.we && req_i.addr == OFFS_HIGH_ADDR |=>
      cfg_o.osr == {$past(req_i.wdata[7:5]), $past(st_q.raw[IDX_OSR_LOW])})
    else $error("oversampling ratio not assembled");

  a_nco_commit: assert property (                                          // RQ15
    req_i.we && req_i.addr == OFFS_LOW_ADDR |=>
      cfg_o.nco_offset[19:16] == $past(st_q.raw[IDX_OFFS_HIGH][3:0]) &&
      cfg_o.nco_offset[15:8] == $past(st_q.raw[IDX_OFFS_MID]) &&
      cfg_o.nco_offset[7:0] == $past(req_i.wdata))
    else $error("nco offset not assembled");

  a_gain_commit: assert property (                                         // RQ16
    req_i.we && req_i.addr == GAIN_LOW_ADDR |=>
      cfg_o.loop_gain == {$past(st_q.raw[IDX_GAIN_HIGH][2:0]), $past(req_i.wdata)})
    else $error("loop gain not assembled");

  // Earlier bytes of a field must leave the running value alone; a glitch
  // here would hand the loop a half-updated setting for one cycle
  a_osr_hold: assert property (                                            // RQ18
    req_i.we && req_i.addr == OSR_LOW_ADDR |=> $stable(cfg_o.osr))
    else $error("oversampling ratio moved before final byte");

  a_nco_hold: assert property (                                            // RQ18
    req_i.we && (req_i.addr == OFFS_HIGH_ADDR || req_i.addr == OFFS_MID_ADDR) |=>
      $stable(cfg_o.nco_offset))
    else $error("nco offset moved before final byte");

  a_gain_hold: assert property (                                           // RQ18
    req_i.we && req_i.addr == GAIN_HIGH_ADDR |=> $stable(cfg_o.loop_gain))
    else $error("loop gain moved before final byte");

  // Mode and filter change only through their own register
  a_ook_hold: assert property (                                            // RQ8
    req_i.we && req_i.addr != MOD_CTRL_TWO_ADDR |=> $stable(cfg_o.ook_mode))
    else $error("modulation type changed by another register");

  a_filter_hold: assert property (                                         // RQ11
    req_i.we && req_i.addr != FILTER_BW_ADDR |=>
      $stable(cfg_o.filter_set) && $stable(cfg_o.decim_exp) &&
      $stable(cfg_o.divide_by_three_skip))
    else $error("filter fields changed by another register");

  a_write_readback: assert property (                                      // RQ11
    req_i.we && req_i.addr == FILTER_BW_ADDR ##1 req_i.re &&
      req_i.addr == FILTER_BW_ADDR && !req_i.we |=>
      rdata_o == $past(req_i.wdata, 2))
    else $error("filter register readback wrong");

  // Shared byte reads back whole, unused middle bit included
  a_offset_readback: assert property (                                     // RQ17
    (req_i.we && req_i.addr == OFFS_HIGH_ADDR) ##1
      (req_i.re && req_i.addr == OFFS_HIGH_ADDR && !req_i.we) |=>
      rdata_o == $past(req_i.wdata, 2))
    else $error("shared offset register readback wrong");

  c_ook_entry:  cover property (!cfg_o.ook_mode ##1 cfg_o.ook_mode);
  c_manchester: cover property (cfg_o.manchester && cfg_o.rate_word != 16'h0000);
  c_nco_update: cover property (req_i.we && req_i.addr == OFFS_LOW_ADDR);
  c_readback:   cover property (req_i.re && req_i.addr == OSR_LOW_ADDR);
  c_back_to_back: cover property (req_i.we ##1 (req_i.re && !req_i.we));

endmodule : rx_modem_parameter_config

// ### verification/host_model.sv
// Host model driving the modem bank register port
`timescale 1ns/10ps
module host_model (
  input  wire logic              mclk_i,
  input  wire logic [7:0]        rdata_i,
  output rx_modem_pkg::reg_req_t req_o
);
  import rx_modem_pkg::*;
  initial req_o = '{addr: 7'h7F, wdata: 8'hFF, we: 1'b0, re: 1'b0};
  // One single-cycle access, then the lines are released
  task automatic xfer(input logic [6:0] a, input logic [7:0] d, input logic w);
    @(posedge mclk_i);
    #1;
    req_o <= '{addr: a, wdata: d, we: w, re: !w};
    @(posedge mclk_i);
    #1;
    // Released lines show the inverse, never a stale value
    req_o <= '{addr: ~a, wdata: ~d, we: 1'b0, re: 1'b0};
  endtask : xfer
  // Back to back: write, write with read, read; the middle read sees the old byte
  task automatic burst(input logic [6:0] a, input logic [7:0] d,
                       output logic [7:0] r_old, output logic [7:0] r_new);
    @(posedge mclk_i);
    #1;
    req_o <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge mclk_i);
    #1;
    req_o <= '{addr: a, wdata: ~d, we: 1'b1, re: 1'b1};
    @(posedge mclk_i);
    #1;
    req_o <= '{addr: a, wdata: d, we: 1'b0, re: 1'b1};
    r_old = rdata_i;
    @(posedge mclk_i);
    #1;
    req_o <= '{addr: ~a, wdata: ~d, we: 1'b0, re: 1'b0};
    r_new = rdata_i;
  endtask : burst
endmodule : host_model

// ### verification/tb.sv
// Self-checking bench of the modem configuration bank
`timescale 1ns/10ps
module tb;
  import rx_modem_pkg::*;
  logic       mclk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic [7:0] rdata_o;
  reg_req_t   req_i;
  modem_cfg_t cfg_o;
  logic       fsk_mode_o;
  logic [7:0] rv;
  int         fails = 0;
  int         num_checks = 0;
  int         cycles = 0;

  initial forever #2 mclk_i = ~mclk_i;
  rx_modem_parameter_config i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .req_i(req_i), .rdata_o(rdata_o), .cfg_o(cfg_o), .fsk_mode_o(fsk_mode_o));
  host_model i_host (.mclk_i(mclk_i), .rdata_i(rdata_o), .req_o(req_i));

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Write, then let one edge pass before looking
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host.xfer(a, d, 1'b1);
    @(posedge mclk_i);
    #1;
  endtask : wr
  task automatic rd(input logic [6:0] a);
    i_host.xfer(a, 8'h00, 1'b0);
    @(posedge mclk_i);
    #1;
    rv = rdata_o;
  endtask : rd
  task automatic t_reset();
    chk(cfg_o.osr, 20'h0);
    chk(cfg_o.nco_offset, 20'h0);
    chk(fsk_mode_o, 20'h1);
    rd(RATE_LOW_ADDR);
    chk(rv, 20'h0);
  endtask : t_reset
  // Rate word commits on low byte; Manchester doubles it
  task automatic t_rate();
    wr(MOD_CTRL_ONE_ADDR, 8'h22);
    wr(RATE_HIGH_ADDR, 8'h12);
    chk(cfg_o.rate_word, 20'h0);
    wr(RATE_LOW_ADDR, 8'h34);
    chk(cfg_o.rate_word, 20'h1234);
    chk(cfg_o.eff_rate, 20'h2468);
    chk(cfg_o.rate_scale, 20'h1);
    wr(MOD_CTRL_ONE_ADDR, 8'h20);
    chk(cfg_o.eff_rate, 20'h1234);
    rd(RATE_HIGH_ADDR);
    chk(rv, 20'h12);
    wr(MOD_CTRL_ONE_ADDR, 8'h02);
    chk(cfg_o.eff_rate, 20'h2468);
    chk(cfg_o.rate_scale, 20'h0);
  endtask : t_rate
  // Shared 21h byte splits between ratio and offset
  task automatic t_recovery();
    wr(OSR_LOW_ADDR, 8'h83);
    chk(cfg_o.osr, 20'h0);
    wr(OFFS_HIGH_ADDR, 8'hA5);
    chk(cfg_o.osr, 20'h583);
    wr(OFFS_MID_ADDR, 8'h3A);
    chk(cfg_o.nco_offset, 20'h0);
    wr(OFFS_LOW_ADDR, 8'h93);
    chk(cfg_o.nco_offset, 20'h53A93);
    wr(GAIN_HIGH_ADDR, 8'h06);
    chk(cfg_o.loop_gain, 20'h0);
    wr(GAIN_LOW_ADDR, 8'h78);
    chk(cfg_o.loop_gain, 20'h678);
    rd(OFFS_HIGH_ADDR);
    chk(rv, 20'hA5);
  endtask : t_recovery
  // Every modulation code, filter written in each mode
  task automatic t_modes();
    logic [7:0] f;
    for (int m = 0; m < 4; m++) begin
      f = {m[0], 3'(m + 2), 4'(m + 5)};
      wr(MOD_CTRL_TWO_ADDR, {6'h00, 2'(m)});
      chk(cfg_o.ook_mode, 20'(m == 1));
      chk(fsk_mode_o, 20'(m != 1));
      wr(FILTER_BW_ADDR, f);
      chk(cfg_o.divide_by_three_skip, 20'(f[7]));
      chk(cfg_o.decim_exp, 20'(f[6:4]));
      chk(cfg_o.filter_set, 20'(f[3:0]));
    end
  endtask : t_modes
  task automatic t_unmapped();
    wr(7'h26, 8'hFF);
    rd(7'h26);
    chk(rv, 20'h0);
    chk(cfg_o.filter_set, 20'h8);
  endtask : t_unmapped
  // Back-to-back accesses; read in a write cycle returns the old byte
  task automatic t_burst();
    logic [7:0] r_old;
    logic [7:0] r_new;
    i_host.burst(FILTER_BW_ADDR, 8'h9E, r_old, r_new);
    chk(r_old, 20'h9E);
    chk(r_new, 20'h61);
    chk(cfg_o.divide_by_three_skip, 20'h0);
    chk(cfg_o.decim_exp, 20'h6);
    chk(cfg_o.filter_set, 20'h1);
    i_host.burst(OFFS_HIGH_ADDR, 8'h3C, r_old, r_new);
    chk(r_old, 20'h3C);
    chk(r_new, 20'hC3);
    chk(cfg_o.osr, 20'h683);
    chk(cfg_o.nco_offset, 20'h53A93);
  endtask : t_burst
  // Program one full setting, final bytes of each field last
  task automatic load(input logic [7:0] f, input logic [7:0] m2, input logic [47:0] crb);
    wr(FILTER_BW_ADDR, f);
    wr(MOD_CTRL_TWO_ADDR, m2);
    wr(OSR_LOW_ADDR, crb[47:40]);
    wr(OFFS_HIGH_ADDR, crb[39:32]);
    wr(OFFS_MID_ADDR, crb[31:24]);
    wr(OFFS_LOW_ADDR, crb[23:16]);
    wr(GAIN_HIGH_ADDR, crb[15:8]);
    wr(GAIN_LOW_ADDR, crb[7:0]);
  endtask : load
  // Host sums, FSK 4.8 kbps, 4.8 kHz deviation: index 2, AFC on, small error
  // Bandwidth 2.4 + 9.6 = 12.0 kHz, next wider filter 12.1 kHz (exp 3, set 4)
  // Ratio 500/4.8 = 104, offset 4.8*2^23/500 = 80531, gain 2+65536/104 = 632
  // OOK 10 kbps: decimation 1, 335.5 kHz filter with skip
  // Ratio 1500/(10/4) = 600, offset 10*2^21/1500 = 13981, gain 2+65536/600 = 111
  task automatic t_rows();
    load(8'h34, 8'h02, 48'h68_01_3A_93_02_78);
    chk(cfg_o.osr, 20'h068);
    chk(cfg_o.nco_offset, 20'h13A93);
    chk(cfg_o.loop_gain, 20'h278);
    chk(fsk_mode_o, 20'h1);
    load(8'h98, 8'h01, 48'h58_40_36_9D_00_6F);
    chk(cfg_o.osr, 20'h258);
    chk(cfg_o.nco_offset, 20'h0369D);
    chk(cfg_o.loop_gain, 20'h06F);
    chk(cfg_o.ook_mode, 20'h1);
    chk(cfg_o.divide_by_three_skip, 20'h1);
  endtask : t_rows
  // Reset in mid-run clears every byte and the read latch
  task automatic t_midreset();
    rd(OFFS_HIGH_ADDR);
    chk(rv, 20'h40);
    rst_b_i = 1'b0;
    @(posedge mclk_i);
    #1;
    chk(rdata_o, 20'h0);
    chk(cfg_o.osr, 20'h0);
    chk(cfg_o.loop_gain, 20'h0);
    chk(cfg_o.filter_set, 20'h0);
    chk(fsk_mode_o, 20'h1);
    rst_b_i = 1'b1;
    rd(OFFS_HIGH_ADDR);
    chk(rv, 20'h0);
    wr(FILTER_BW_ADDR, 8'h34);
    chk(cfg_o.filter_set, 20'h4);
  endtask : t_midreset
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // Hang guard, far above the roughly 150 cycles needed
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    #1;
    rst_b_i = 1'b1;
    t_reset();
    t_rate();
    t_recovery();
    t_modes();
    t_unmapped();
    t_burst();
    t_rows();
    t_midreset();
    print_verdict();
  end
endmodule : tb
